// ===== core/hbu_params.svh
`ifndef HBU_PARAMS_SVH
`define HBU_PARAMS_SVH
// register byte offsets
`define HBU_OFS_CTL0 8'h20
`define HBU_OFS_CTL1 8'h21
`define HBU_OFS_AMH 8'h22
`define HBU_OFS_AML 8'h23
`define HBU_OFS_DMH 8'h24
`define HBU_OFS_DML 8'h25
// control 0 field positions
`define HBU_C0_MODE_HI 7
`define HBU_C0_MODE_LO 6
`define HBU_C0_PROG 5
`define HBU_C0_RNG1 1
`define HBU_C0_RNG0 0
// control 1 field positions
`define HBU_C1_DBE 7
`define HBU_C1_MBH 6
`define HBU_C1_MBL 5
`define HBU_C1_RWE1 4
`define HBU_C1_RW1 3
`define HBU_C1_RWE0 2
`define HBU_C1_RW0 1
`define HBU_C1_SZ8 0
// reset values
`define HBU_RST_BYTE 8'h00
`endif

// ===== core/hbu_pkg.sv
package hbu_pkg;
	typedef enum logic [1:0]
	{
		HBU_OFF = 2'h0,
		HBU_SWI_DUAL = 2'h1,
		HBU_DBG_FULL = 2'h2,
		HBU_DBG_DUAL = 2'h3
	} hbu_mode_t;
	typedef struct packed
	{
		logic [15:0] addr;
		logic [15:0] data;
		logic rd;
		logic valid;
		logic fetch;
		logic exec;
	} hbu_cyc_t;
	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} hbu_bus_t;
endpackage

// ===== core/hbu_breakpoint.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbu_params.svh"
module hbu_breakpoint
	import hbu_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [15:0] cpu_addr_i,
	input wire logic [15:0] cpu_data_i,
	input wire logic cpu_rd_i,
	input wire logic cpu_valid_i,
	input wire logic cpu_fetch_i,
	input wire logic cpu_exec_i,
	input wire logic cpu_boundary_i,
	input wire logic cpu_ack_i,
	input wire logic background_debug_active_i,
	input wire logic background_debug_enable_i,
	input wire logic single_step_trace_cmd_i,
	output logic swi_req_o,
	output logic dbg_req_o
);
	logic [7:0] ctl0_q;
	logic [7:0] ctl1_q;
	logic [7:0] amh_q;
	logic [7:0] aml_q;
	logic [7:0] dmh_q;
	logic [7:0] dml_q;
	logic [7:0] rdata_q;
	logic pend;
	logic swi_q;
	logic dbg_q;
	hbu_cyc_t cyc;
	hbu_mode_t mode;
	logic mode_select_hi;
	logic mode_select_lo;
	logic program_only_break;
	logic first_range_ctl;
	logic second_range_ctl;
	logic data_reg_enable;
	logic mask_high_byte;
	logic mask_low_byte;
	logic rw_compare_enable_0;
	logic rw_compare_value_0;
	logic rw_compare_enable_1;
	logic rw_compare_value_1;
	logic byte_size_select;
	logic dual;
	logic addr0_hit;
	logic addr1_hit;
	logic data_hit;
	logic rw0_ok;
	logic rw1_ok;
	logic kind0_ok;
	logic kind1_ok;
	logic bp0;
	logic bp1;
	logic hit;
	logic raise;
	logic held_q;
	logic fire;
	logic [7:0] rdata_d;
	logic wr_ctl0;
	logic wr_ctl1;
	logic wr_amh;
	logic wr_aml;
	logic wr_dmh;
	logic wr_dml;

	assign cyc = '{addr: cpu_addr_i, data: cpu_data_i, rd: cpu_rd_i, valid: cpu_valid_i,
		fetch: cpu_fetch_i, exec: cpu_exec_i};
	assign mode_select_hi = ctl0_q[`HBU_C0_MODE_HI];
	assign mode_select_lo = ctl0_q[`HBU_C0_MODE_LO];
	assign mode = hbu_mode_t'({mode_select_hi, mode_select_lo});
	assign program_only_break = ctl0_q[`HBU_C0_PROG];
	assign second_range_ctl = ctl0_q[`HBU_C0_RNG1];
	assign first_range_ctl = ctl0_q[`HBU_C0_RNG0];
	assign data_reg_enable = ctl1_q[`HBU_C1_DBE];
	assign mask_high_byte = ctl1_q[`HBU_C1_MBH];
	assign mask_low_byte = ctl1_q[`HBU_C1_MBL];
	assign rw_compare_enable_1 = ctl1_q[`HBU_C1_RWE1];
	assign rw_compare_value_1 = ctl1_q[`HBU_C1_RW1];
	assign rw_compare_enable_0 = ctl1_q[`HBU_C1_RWE0];
	assign rw_compare_value_0 = ctl1_q[`HBU_C1_RW0];
	// size select is stored only; no comparator reads it in any mode
	assign byte_size_select = ctl1_q[`HBU_C1_SZ8];
	assign dual = (mode == HBU_SWI_DUAL) || (mode == HBU_DBG_DUAL);

	// address comparators; low byte dropped for range compare
	assign addr0_hit = (cyc.addr[15:8] == amh_q) &&
		(!first_range_ctl || cyc.addr[7:0] == aml_q);
	assign addr1_hit = (cyc.addr[15:8] == dmh_q) &&
		(!second_range_ctl || cyc.addr[7:0] == dml_q);
	// data comparator for full mode, each byte maskable
	assign data_hit = (mask_high_byte || cyc.data[15:8] == dmh_q) &&
		(mask_low_byte || cyc.data[7:0] == dml_q);

	// read/write qualification, ignored in soft-interrupt mode
	assign rw0_ok = (mode == HBU_SWI_DUAL) || !rw_compare_enable_0 ||
		(cyc.rd == rw_compare_value_0);
	assign rw1_ok = (mode == HBU_SWI_DUAL) || !rw_compare_enable_1 ||
		(cyc.rd == rw_compare_value_1);

	// access kind: soft-interrupt mode always tags executed fetches
	always_comb
	begin
		if (mode == HBU_SWI_DUAL)
		begin
			kind0_ok = cyc.fetch && cyc.exec;
		end
		else if (program_only_break)
		begin
			kind0_ok = cyc.fetch && cyc.exec;
		end
		else
		begin
			kind0_ok = 1'b1;
		end
	end
	// tag-based breaks blocked during single step
	assign kind1_ok = kind0_ok &&
		!(single_step_trace_cmd_i && (mode == HBU_SWI_DUAL || program_only_break));

	always_comb
	begin
		bp0 = 1'b0;
		bp1 = 1'b0;
		unique case (mode)
			HBU_OFF:
			begin
				bp0 = 1'b0;
			end
			HBU_SWI_DUAL, HBU_DBG_DUAL:
			begin
				bp0 = addr0_hit && rw0_ok && kind1_ok;
				bp1 = data_reg_enable && addr1_hit && rw1_ok && kind1_ok;
			end
			HBU_DBG_FULL:
			begin
				bp0 = addr0_hit && rw0_ok && kind1_ok &&
					(!data_reg_enable || program_only_break || data_hit);
			end
		endcase
	end

	assign hit = cyc.valid && (bp0 || (dual && bp1));
	assign pend = swi_q || dbg_q;
	// nothing gates on debug enable here; debug code handles disabled case
	assign raise = hit && !background_debug_active_i && !pend;

	// debug entry waits for instruction boundary unless fetch-tagged
	logic boundary_ok;
	assign boundary_ok = (mode == HBU_SWI_DUAL) || program_only_break || cpu_boundary_i;
	assign fire = (raise && boundary_ok) ||
		(held_q && (mode == HBU_DBG_FULL || mode == HBU_DBG_DUAL) && cpu_boundary_i &&
		!background_debug_active_i && !pend);

	// a match between boundaries is kept, else one-cycle bus matches would be lost
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			held_q <= 1'b0;
		end
		else if (fire || background_debug_active_i || mode == HBU_OFF)
		begin
			held_q <= 1'b0;
		end
		else if (raise && !boundary_ok)
		begin
			held_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			swi_q <= 1'b0;
		end
		else if (swi_q && cpu_ack_i)
		begin
			swi_q <= 1'b0;
		end
		else if (fire && mode == HBU_SWI_DUAL)
		begin
			swi_q <= 1'b1;
		end
	end

	// with debug disabled the match is simply dropped
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			dbg_q <= 1'b0;
		end
		else if (dbg_q && cpu_ack_i)
		begin
			dbg_q <= 1'b0;
		end
		else if (fire && mode != HBU_SWI_DUAL && background_debug_enable_i)
		begin
			dbg_q <= 1'b1;
		end
	end

	assign swi_req_o = swi_q;
	assign dbg_req_o = dbg_q;

	// register writes; each byte has its own decode and flop
	assign wr_ctl0 = reg_wr_i && (reg_addr_i == `HBU_OFS_CTL0);
	assign wr_ctl1 = reg_wr_i && (reg_addr_i == `HBU_OFS_CTL1);
	assign wr_amh = reg_wr_i && (reg_addr_i == `HBU_OFS_AMH);
	assign wr_aml = reg_wr_i && (reg_addr_i == `HBU_OFS_AML);
	assign wr_dmh = reg_wr_i && (reg_addr_i == `HBU_OFS_DMH);
	assign wr_dml = reg_wr_i && (reg_addr_i == `HBU_OFS_DML);

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ctl0_q <= `HBU_RST_BYTE;
		end
		else if (wr_ctl0)
		begin
			ctl0_q <= reg_wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ctl1_q <= `HBU_RST_BYTE;
		end
		else if (wr_ctl1)
		begin
			ctl1_q <= reg_wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			amh_q <= `HBU_RST_BYTE;
		end
		else if (wr_amh)
		begin
			amh_q <= reg_wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			aml_q <= `HBU_RST_BYTE;
		end
		else if (wr_aml)
		begin
			aml_q <= reg_wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			dmh_q <= `HBU_RST_BYTE;
		end
		else if (wr_dmh)
		begin
			dmh_q <= reg_wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			dml_q <= `HBU_RST_BYTE;
		end
		else if (wr_dml)
		begin
			dml_q <= reg_wdata_i;
		end
	end

	// reads: one cycle later; unmapped offsets and idle cycles read zero
	always_comb
	begin
		rdata_d = `HBU_RST_BYTE;
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				`HBU_OFS_CTL0: rdata_d = {ctl0_q[7:6], ctl0_q[5], 3'h0, ctl0_q[1:0]};
				`HBU_OFS_CTL1: rdata_d = {ctl1_q[7:1], byte_size_select};
				`HBU_OFS_AMH: rdata_d = amh_q;
				`HBU_OFS_AML: rdata_d = aml_q;
				`HBU_OFS_DMH: rdata_d = dmh_q;
				`HBU_OFS_DML: rdata_d = dml_q;
				default: rdata_d = `HBU_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rdata_q <= `HBU_RST_BYTE;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;
endmodule
`default_nettype wire

// ===== tb/hbu_breakpoint_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module hbu_breakpoint_assertions (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic cpu_rd_i,
	input wire logic cpu_valid_i,
	input wire logic cpu_fetch_i,
	input wire logic cpu_exec_i,
	input wire logic cpu_boundary_i,
	input wire logic cpu_ack_i,
	input wire logic background_debug_active_i,
	input wire logic background_debug_enable_i,
	input wire logic single_step_trace_cmd_i,
	input wire logic swi_req_o,
	input wire logic dbg_req_o
);
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	a_no_active_req: assert property (($rose(swi_req_o) || $rose(dbg_req_o))
		|-> !$past(background_debug_active_i)) else $error("request while debug active");
	a_one_req: assert property (!(swi_req_o && dbg_req_o))
		else $error("both requests high");
	a_req_hold: assert property ((swi_req_o || dbg_req_o) && !cpu_ack_i
		|=> $stable({swi_req_o, dbg_req_o})) else $error("request dropped early");
	a_ack_clears: assert property ((swi_req_o || dbg_req_o) && cpu_ack_i
		|=> !swi_req_o && !dbg_req_o) else $error("request kept after ack");
	a_dbg_enabled: assert property ($rose(dbg_req_o) |-> $past(background_debug_enable_i))
		else $error("debug request while disabled");
	a_swi_tagged: assert property ($rose(swi_req_o)
		|-> $past(cpu_valid_i && cpu_fetch_i && cpu_exec_i)) else $error("swi not on fetch");
	a_swi_read: assert property ($rose(swi_req_o) |-> $past(cpu_rd_i))
		else $error("swi on write");
	a_trace_inhibit: assert property ($rose(swi_req_o) |-> !$past(single_step_trace_cmd_i))
		else $error("tag break during trace");
	a_dbg_boundary: assert property ($rose(dbg_req_o) |-> $past(cpu_boundary_i) ||
		$past(cpu_fetch_i && cpu_exec_i)) else $error("debug request off boundary");
endmodule
bind hbu_breakpoint hbu_breakpoint_assertions chk_u (.clk_i, .rst_b_i, .cpu_rd_i, .cpu_valid_i,
	.cpu_fetch_i, .cpu_exec_i, .cpu_boundary_i, .cpu_ack_i, .background_debug_active_i,
	.background_debug_enable_i, .single_step_trace_cmd_i, .swi_req_o, .dbg_req_o);
`default_nettype wire

// ===== tb/hbu_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module hbu_cpu_model
	import hbu_pkg::*;
(
	input wire logic clk_i,
	input wire logic req_i,
	output hbu_cyc_t cyc_o,
	output logic bnd_o,
	output logic ack_o
);
	int dly = 0;
	logic [7:0] cnt = 8'h00;
	initial cyc_o = '0;
	initial bnd_o = 1'b0;
	initial ack_o = 1'b0;
	// a boundary every other cycle, so non-tagged breaks wait
	always @(posedge clk_i) bnd_o <= ~bnd_o;
	always @(posedge clk_i)
		if (!req_i || ack_o)
		begin
			cnt <= 8'h00;
			ack_o <= 1'b0;
		end
		else
		begin
			cnt <= cnt + 8'h01;
			ack_o <= (cnt == 8'(dly));
		end
	// released lines show the inverse, not a stale match
	task automatic cyc(input hbu_cyc_t c);
		@(posedge clk_i);
		cyc_o <= c;
		@(posedge clk_i);
		cyc_o <= '{~c.addr, ~c.data, ~c.rd, 1'b0, 1'b0, 1'b0};
	endtask
endmodule
`default_nettype wire

// ===== tb/hbu_breakpoint_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module hbu_breakpoint_tb_top;
	import hbu_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	hbu_bus_t bus = '0;
	logic act = 1'b0, en = 1'b1, trc = 1'b0, bnd, ack, swi, dbg;
	hbu_cyc_t cyc;
	logic [7:0] rdata;
	int fails = 0, compares = 0, n = 0;
	always #10 clk_i = ~clk_i;
	hbu_breakpoint dut_u (.clk_i, .rst_b_i, .reg_addr_i(bus.addr), .reg_wdata_i(bus.wdata),
		.reg_wr_i(bus.wr), .reg_rd_i(bus.rd), .reg_rdata_o(rdata), .cpu_addr_i(cyc.addr),
		.cpu_data_i(cyc.data), .cpu_rd_i(cyc.rd), .cpu_valid_i(cyc.valid),
		.cpu_fetch_i(cyc.fetch), .cpu_exec_i(cyc.exec), .cpu_boundary_i(bnd), .cpu_ack_i(ack),
		.background_debug_active_i(act), .background_debug_enable_i(en),
		.single_step_trace_cmd_i(trc), .swi_req_o(swi), .dbg_req_o(dbg));
	hbu_cpu_model model_u (.clk_i, .req_i(swi | dbg), .cyc_o(cyc), .bnd_o(bnd), .ack_o(ack));
	task automatic final_report;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] g, e);
		compares++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value at %0t: reg %h not %h", $time, g, e);
		end
	endtask
	task automatic chkr(input logic [1:0] g, e);
		compares++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value at %0t: req %b not %b", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_i);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_i);
		bus <= '0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge clk_i);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_i);
		bus <= '0;
		#1 chk8(rdata, e);
	endtask
	// k is read, fetch, execute; s is debug active, enable, trace
	task automatic hit(input logic [7:0] c0, c1, input logic [15:0] a, input logic [2:0] k,
		input logic [1:0] e, input logic [15:0] d = 16'h5678, input logic [2:0] s = 3'b010);
		int i;
		wr(8'h20, c0);
		wr(8'h21, c1);
		@(posedge clk_i);
		{act, en, trc} <= s;
		model_u.cyc('{a, d, k[2], 1'b1, k[1], k[0]});
		for (i = 0; i < 6 && (swi | dbg) === 1'b0; i++) @(posedge clk_i) #1;
		chkr({swi, dbg}, e);
		for (i = 0; i < 20 && (swi | dbg) !== 1'b0; i++) @(posedge clk_i) #1;
		@(posedge clk_i);
		{act, en, trc} <= 3'b010;
	endtask
	task automatic t_regs;
		int i;
		for (i = 0; i < 6; i++) rd(8'h20 + 8'(i), 8'h00);
		for (i = 0; i < 4; i++)
		begin
			wr(8'h22 + 8'(i), 8'h12 + 8'(i) * 8'h22);
			rd(8'h22 + 8'(i), 8'h12 + 8'(i) * 8'h22);
		end
		rd(8'h30, 8'h00);
	endtask
	task automatic t_modes;
		hit(8'h03, 8'h00, 16'h1234, 3'b111, 2'b00);
		hit(8'h43, 8'h00, 16'h1234, 3'b111, 2'b10);
		hit(8'h43, 8'h00, 16'h1234, 3'b100, 2'b00);
		hit(8'hc3, 8'h00, 16'h1234, 3'b100, 2'b01);
		hit(8'h81, 8'h80, 16'h1234, 3'b100, 2'b01);
		hit(8'h81, 8'h80, 16'h1234, 3'b100, 2'b00, 16'h5600);
		hit(8'h81, 8'ha0, 16'h1234, 3'b100, 2'b01, 16'h5600);
		hit(8'h81, 8'hc0, 16'h1234, 3'b100, 2'b01, 16'h0078);
	endtask
	task automatic t_guards;
		hit(8'h43, 8'h00, 16'h1234, 3'b111, 2'b00, 16'h5678, 3'b110);
		hit(8'hc3, 8'h00, 16'h1234, 3'b111, 2'b00, 16'h5678, 3'b000);
		hit(8'h43, 8'h00, 16'h1234, 3'b111, 2'b00, 16'h5678, 3'b011);
		hit(8'he3, 8'h00, 16'h1234, 3'b110, 2'b00);
		model_u.dly = 3;
		hit(8'he3, 8'h00, 16'h1234, 3'b111, 2'b01);
	endtask
	task automatic t_second;
		hit(8'h43, 8'h81, 16'h5678, 3'b111, 2'b10);
		hit(8'h43, 8'h01, 16'h5678, 3'b111, 2'b00);
		hit(8'h41, 8'h80, 16'h56ff, 3'b111, 2'b10);
		hit(8'h42, 8'h00, 16'h12ff, 3'b111, 2'b10);
		hit(8'h43, 8'h00, 16'h12ff, 3'b111, 2'b00);
	endtask
	task automatic t_rw;
		hit(8'h43, 8'h04, 16'h1234, 3'b111, 2'b10);
		hit(8'hc3, 8'h04, 16'h1234, 3'b100, 2'b00);
		hit(8'hc3, 8'h04, 16'h1234, 3'b000, 2'b01);
		hit(8'hc3, 8'h98, 16'h5678, 3'b100, 2'b01);
		hit(8'hc3, 8'h90, 16'h5678, 3'b100, 2'b00);
	endtask
	always @(posedge clk_i)
	begin
		n++;
		if (n == 20000)
		begin
			fails++;
			final_report;
		end
	end
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_regs;
		t_modes;
		t_guards;
		t_second;
		t_rw;
		final_report;
	end
endmodule
`default_nettype wire
